// *** hw/seece_engine.sv ***
// Command engine of a 16 x 16 serial EEPROM behind a four-wire serial link.
// How it works
// - Frame is start bit one, 2-bit opcode, 6-bit address, optional 16-bit data.
// - Opcode 10 reads, 01 writes, 11 erases, 00 picks control by top address bits.
// - Starts write-disabled; enable holds until disable frame executes.
// - Read shifts a zero dummy bit then the word MSB first on rising clock.
// - Disable frame blocks programming, effective when select falls.
// - Reads behave the same whether programming is enabled or not.
// - Word erase sets every bit of the addressed word to one.
// - Whole-array erase sets every bit of every word to one.
// - Select falling after a programming frame starts a timed busy cycle.
// - With select high around programming, data-out is low busy, high ready.
// - Data-out is high impedance whenever select is low.
// - Toggling select during programming never disturbs the cycle.
// - After ready, a clocked-in start bit returns data-out to high impedance.
// - That start bit may begin a new frame; dropping select resets sequencing.
// - Write and fill need no preceding erase.
// - Enable 11, fill 01, read and write 00 plus 4-bit word address.
`timescale 1ns/1ns
module seece_engine
    import seece_pkg::*;
#(
    parameter int PROGRAM_CYCLES = SEECE_PROGRAM_CYCLES
)(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic select_i,
    input wire logic serial_clock_in_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic busy_o,
    output logic write_enabled_o
);

    // The busy timer is 24 bits wide, so longer cycles cannot be counted.
    if (PROGRAM_CYCLES < 1 || PROGRAM_CYCLES > 16777215)
    begin : g_bad_cycles
        $error("seece_engine: PROGRAM_CYCLES out of range");
    end

    // Two-stage synchronisers for the three link inputs.
    logic [2:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic link_clk_prev_r, link_clk_prev_nxt;
    logic sel_prev_r, sel_prev_nxt;

    always_comb
    begin
        sync1_nxt = {select_i, serial_clock_in_i, serial_in_i};
        sync2_nxt = sync1_r;
        link_clk_prev_nxt = sync2_r[1];
        sel_prev_nxt = sync2_r[2];
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            link_clk_prev_r <= 1'b0;
            sel_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            link_clk_prev_r <= link_clk_prev_nxt;
            sel_prev_r <= sel_prev_nxt;
        end
    end

    logic sel, din, link_clk_rise, sel_fall;
    assign sel = sync2_r[2];
    assign din = sync2_r[0];
    assign link_clk_rise = sync2_r[1] & ~link_clk_prev_r & sel;
    assign sel_fall = sel_prev_r & ~sel;

    logic [15:0] mem_r [SEECE_WORDS];
    seece_state_e state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [7:0] hdr_r, hdr_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic wen_r, wen_nxt;
    seece_prog_s pend_r, pend_nxt;
    seece_prog_s prog_r, prog_nxt;
    logic wdis_pend_r, wdis_pend_nxt;
    logic wen_pend_r, wen_pend_nxt;
    logic [23:0] timer_r, timer_nxt;
    logic busy_r, busy_nxt;
    logic status_r, status_nxt;
    logic dout_r, dout_nxt;
    logic oe_r, oe_nxt;
    logic commit;

    function automatic logic [3:0] word_addr(input logic [7:0] h);
        word_addr = h[SEECE_ADDR_W-1:0];
    endfunction : word_addr

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        hdr_nxt = hdr_r;
        shift_nxt = shift_r;
        wen_nxt = wen_r;
        pend_nxt = pend_r;
        prog_nxt = prog_r;
        wdis_pend_nxt = wdis_pend_r;
        wen_pend_nxt = wen_pend_r;
        timer_nxt = timer_r;
        busy_nxt = busy_r;
        status_nxt = status_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        commit = 1'b0;
        // The programming timer runs regardless of select activity.
        if (busy_r)
        begin
            if (timer_r == 24'h000001)
            begin
                busy_nxt = 1'b0;
                commit = 1'b1;
            end
            timer_nxt = timer_r - 24'h000001;
        end
        if (!sel)
        begin
            // Dropping select resets sequencing and tri-states the output.
            oe_nxt = 1'b0;
            state_nxt = SEECE_IDLE;
            if (sel_fall)
            begin
                if (wdis_pend_r)
                    wen_nxt = 1'b0;
                if (wen_pend_r)
                    wen_nxt = 1'b1;
                if (pend_r.kind != SEECE_PG_NONE && !busy_r)
                begin
                    prog_nxt = pend_r;
                    busy_nxt = 1'b1;
                    status_nxt = 1'b1;
                    timer_nxt = 24'(PROGRAM_CYCLES);
                end
                pend_nxt = SEECE_PROG_RESET;
                wdis_pend_nxt = 1'b0;
                wen_pend_nxt = 1'b0;
            end
        end
        else
        begin
            if (status_r && state_r == SEECE_IDLE)
            begin
                // Status shown on data-out from the start of a programming cycle until a start bit clears it.
                oe_nxt = 1'b1;
                dout_nxt = ~busy_r;
            end
            if (link_clk_rise)
            begin
                unique case (state_r)
                    SEECE_IDLE:
                    begin
                        // A busy device takes no new instruction.
                        if (din && !busy_r)
                        begin
                            if (status_r)
                            begin
                                status_nxt = 1'b0;
                                oe_nxt = 1'b0;
                            end
                            state_nxt = SEECE_HDR;
                            cnt_nxt = 5'h00;
                        end
                    end
                    SEECE_HDR:
                    begin
                        hdr_nxt = {hdr_r[6:0], din};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == SEECE_HDR_BITS - 5'h01)
                        begin
                            cnt_nxt = 5'h00;
                            state_nxt = SEECE_DONE;
                            unique case (hdr_r[6:5])
                                SEECE_OP_READ:
                                begin
                                    // Reads ignore the enable state entirely.
                                    shift_nxt = mem_r[word_addr({hdr_r[6:0], din})];
                                    oe_nxt = 1'b1;
                                    dout_nxt = 1'b0;
                                    state_nxt = SEECE_READ;
                                end
                                SEECE_OP_WRITE:
                                    state_nxt = SEECE_DATA;
                                SEECE_OP_ERASE:
                                    if (wen_r)
                                        pend_nxt = '{SEECE_PG_WORD, word_addr({hdr_r[6:0], din}),
                                                     SEECE_ERASED_WORD};
                                SEECE_OP_CTRL:
                                    unique case (hdr_r[4:3])
                                        SEECE_CTL_DISABLE: wdis_pend_nxt = 1'b1;
                                        SEECE_CTL_ENABLE: wen_pend_nxt = 1'b1;
                                        SEECE_CTL_FILL: state_nxt = SEECE_DATA;
                                        SEECE_CTL_CLEAR:
                                            if (wen_r)
                                                pend_nxt = '{SEECE_PG_ALL, 4'h0,
                                                             SEECE_ERASED_WORD};
                                    endcase
                            endcase
                        end
                    end
                    SEECE_DATA:
                    begin
                        shift_nxt = {shift_r[14:0], din};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == SEECE_DATA_BITS - 5'h01)
                        begin
                            state_nxt = SEECE_DONE;
                            // Writes overwrite directly, no erase needed.
                            if (wen_r)
                                pend_nxt = '{(hdr_r[7:6] == SEECE_OP_WRITE) ?
                                             SEECE_PG_WORD : SEECE_PG_ALL,
                                             word_addr(hdr_r), {shift_r[14:0], din}};
                        end
                    end
                    SEECE_READ:
                    begin
                        dout_nxt = shift_r[15];
                        shift_nxt = {shift_r[14:0], 1'b0};
                        cnt_nxt = cnt_r + 5'h01;
                        if (cnt_r == SEECE_DATA_BITS)
                        begin
                            oe_nxt = 1'b0;
                            state_nxt = SEECE_DONE;
                        end
                    end
                    SEECE_DONE:
                    begin
                        // Extra clocks past the frame are ignored until select drops.
                        state_nxt = SEECE_DONE;
                    end
                    default: state_nxt = SEECE_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_r <= SEECE_IDLE;
            cnt_r <= 5'h00;
            hdr_r <= 8'h00;
            shift_r <= 16'h0000;
            wen_r <= 1'b0;
            pend_r <= SEECE_PROG_RESET;
            prog_r <= SEECE_PROG_RESET;
            wdis_pend_r <= 1'b0;
            wen_pend_r <= 1'b0;
            timer_r <= 24'h000000;
            busy_r <= 1'b0;
            status_r <= 1'b0;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hdr_r <= hdr_nxt;
            shift_r <= shift_nxt;
            wen_r <= wen_nxt;
            pend_r <= pend_nxt;
            prog_r <= prog_nxt;
            wdis_pend_r <= wdis_pend_nxt;
            wen_pend_r <= wen_pend_nxt;
            timer_r <= timer_nxt;
            busy_r <= busy_nxt;
            status_r <= status_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
        end
    end

    // The array is written at the end of the timed cycle, as cells settle then.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < SEECE_WORDS; i++)
                mem_r[i] <= SEECE_MEM_RESET;
        end
        else if (commit)
        begin
            for (int i = 0; i < SEECE_WORDS; i++)
                if (prog_r.kind == SEECE_PG_ALL ||
                    (prog_r.kind == SEECE_PG_WORD && prog_r.addr == 4'(i)))
                    mem_r[i] <= prog_r.data;
        end
    end

    assign serial_out_o = dout_r;
    assign serial_out_oe_o = oe_r;
    assign busy_o = busy_r;
    assign write_enabled_o = wen_r;

endmodule : seece_engine

// *** hw/seece_pkg.sv ***
// Shared constants and types for the serial EEPROM command engine.
package seece_pkg;

    localparam int SEECE_WORDS = 16;
    localparam int SEECE_DATA_W = 16;
    localparam int SEECE_ADDR_W = 4;
    localparam int SEECE_FIELD_ADDR_W = 6;
    localparam int SEECE_OPCODE_W = 2;

    // Bits after the start bit: opcode plus address field, then the data word alone.
    localparam logic [4:0] SEECE_HDR_BITS = 5'h08;
    localparam logic [4:0] SEECE_DATA_BITS = 5'h10;

    localparam logic [1:0] SEECE_OP_CTRL = 2'h0;
    localparam logic [1:0] SEECE_OP_WRITE = 2'h1;
    localparam logic [1:0] SEECE_OP_READ = 2'h2;
    localparam logic [1:0] SEECE_OP_ERASE = 2'h3;

    localparam logic [1:0] SEECE_CTL_DISABLE = 2'h0;
    localparam logic [1:0] SEECE_CTL_FILL = 2'h1;
    localparam logic [1:0] SEECE_CTL_CLEAR = 2'h2;
    localparam logic [1:0] SEECE_CTL_ENABLE = 2'h3;

    localparam logic [15:0] SEECE_ERASED_WORD = 16'hffff;
    localparam logic [15:0] SEECE_MEM_RESET = 16'hffff;

    // Programming time in microseconds, and its cycle count at the 50 MHz clock.
    localparam int SEECE_PROGRAM_TIME_US = 10;
    localparam int SEECE_CLK_MHZ = 50;
    localparam int SEECE_PROGRAM_CYCLES = SEECE_PROGRAM_TIME_US * SEECE_CLK_MHZ;

    typedef enum logic [2:0] {
        SEECE_IDLE = 3'h0,
        SEECE_HDR = 3'h1,
        SEECE_DATA = 3'h2,
        SEECE_READ = 3'h3,
        SEECE_DONE = 3'h4
    } seece_state_e;

    typedef enum logic [1:0] {
        SEECE_PG_NONE = 2'h0,
        SEECE_PG_WORD = 2'h1,
        SEECE_PG_ALL = 2'h2
    } seece_prog_e;

    typedef struct packed {
        seece_prog_e kind;
        logic [3:0] addr;
        logic [15:0] data;
    } seece_prog_s;

    localparam logic [21:0] SEECE_PROG_RESET = 22'h000000;

endpackage : seece_pkg

// *** verif/seece_engine_assertions.sv ***
// Port-level assertions for the serial EEPROM command engine.
`timescale 1ns/1ns
module seece_engine_assertions #(
    parameter int PROGRAM_CYCLES = 500
)(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic select_i,
    input wire logic serial_clock_in_i,
    input wire logic serial_in_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic busy_o,
    input wire logic write_enabled_o
);
    int cnt_r;
    int cnt_nxt;
    always_comb
    begin
        cnt_nxt = busy_o ? cnt_r + 1 : 0;
    end
    always_ff @(posedge mclk_i)
    begin
        cnt_r <= reset_i ? 0 : cnt_nxt;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    property p_oe_off;
        !select_i [*6] |-> !serial_out_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data-out driven unselected");
    property p_busy_show;
        (select_i && busy_o) [*6] |-> serial_out_oe_o && !serial_out_o;
    endproperty
    a_busy_show: assert property (p_busy_show) else $error("busy not shown");
    property p_ready_show;
        $fell(busy_o) ##0 (select_i && !serial_clock_in_i) [*6] |-> serial_out_oe_o && serial_out_o;
    endproperty
    a_ready_show: assert property (p_ready_show) else $error("ready not shown");
    property p_busy_len;
        $fell(busy_o) |-> cnt_r >= PROGRAM_CYCLES - 2 && cnt_r <= PROGRAM_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_rose_wen;
        $rose(busy_o) |-> write_enabled_o;
    endproperty
    a_rose_wen: assert property (p_rose_wen) else $error("programmed while locked");
    property p_rose_sel;
        $rose(busy_o) |-> !select_i;
    endproperty
    a_rose_sel: assert property (p_rose_sel) else $error("busy before select fall");
    property p_wen_sel;
        $changed(write_enabled_o) |-> !select_i;
    endproperty
    a_wen_sel: assert property (p_wen_sel) else $error("enable changed in frame");
    // Eight low clock cycles rule out a start bit still in the synchroniser.
    property p_clear;
        (select_i && !serial_clock_in_i) [*8] ##0 (serial_out_oe_o && serial_out_o)
            |=> serial_out_oe_o;
    endproperty
    a_clear: assert property (p_clear) else $error("ready cleared early");
endmodule : seece_engine_assertions
bind seece_engine seece_engine_assertions #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .select_i(select_i),
    .serial_clock_in_i(serial_clock_in_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o),
    .busy_o(busy_o),
    .write_enabled_o(write_enabled_o)
);

// *** verif/seece_engine_tb.sv ***
// Self-checking bench for the serial EEPROM command engine.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module seece_engine_tb
    import seece_pkg::*;
;
    localparam int PC = 60;
    logic mclk_i;
    logic reset_i;
    logic sel, sclk, sdin, oe, out, busy, wen;
    int n_fail = 0;
    int total_checks = 0;
    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    seece_engine #(.PROGRAM_CYCLES(PC)) DUT (.mclk_i(mclk_i), .reset_i(reset_i),
        .select_i(sel), .serial_clock_in_i(sclk), .serial_in_i(sdin), .serial_out_o(out),
        .serial_out_oe_o(oe), .busy_o(busy), .write_enabled_o(wen));
    seece_host u_host (.mclk_i(mclk_i), .oe_i(oe), .out_i(out), .select_o(sel),
        .serial_clock_in_o(sclk), .serial_in_o(sdin));
    task final_report;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task wait_idle;
        int i;
        u_host.wt(8);
        for (i = 0; i < 200 && busy !== 1'b0; i++) u_host.wt(1);
        `CHK(busy, 1'b0)
    endtask : wait_idle
    task rd(input logic [3:0] a, input logic [15:0] e);
        u_host.frame(SEECE_OP_READ, {2'h0, a}, 17, 17'h0);
        `CHK(u_host.q, {1'b0, e})
    endtask : rd
    task ctl(input logic [1:0] c, input int n, input logic [15:0] d);
        u_host.frame(SEECE_OP_CTRL, {c, 4'h5}, n, {1'b0, d});
    endtask : ctl
    task t_reset;
        `CHK({wen, busy, oe}, 3'h0)
        $display("test reset done");
    endtask : t_reset
    task t_locked;
        u_host.frame(SEECE_OP_WRITE, 6'h02, 16, 17'h0);
        `CHK(busy, 1'b0)
        rd(4'h2, SEECE_MEM_RESET);
        $display("test locked done");
    endtask : t_locked
    task t_write;
        ctl(SEECE_CTL_ENABLE, 0, 16'h0);
        `CHK(wen, 1'b1)
        u_host.frame(SEECE_OP_WRITE, 6'h05, 16, 17'h1234);
        `CHK(busy, 1'b1)
        u_host.sel(1'b1);
        u_host.wt(6);
        `CHK({oe, out}, 2'h2)
        u_host.sel(1'b0);
        u_host.wt(6);
        `CHK(oe, 1'b0)
        u_host.sel(1'b1);
        wait_idle();
        u_host.wt(6);
        `CHK({oe, out}, 2'h3)
        // A lone start bit clears the ready display; dropping select then aborts it.
        u_host.bit_(1'b1);
        `CHK(oe, 1'b0)
        u_host.sel(1'b0);
        u_host.wt(4);
        rd(4'h5, 16'h1234);
        $display("test write done");
    endtask : t_write
    task t_fill_erase;
        ctl(SEECE_CTL_FILL, 16, 16'ha5a5);
        wait_idle();
        u_host.frame(SEECE_OP_ERASE, 6'h03, 0, 17'h0);
        `CHK(busy, 1'b1)
        wait_idle();
        rd(4'h3, SEECE_ERASED_WORD);
        rd(4'h4, 16'ha5a5);
        $display("test fill erase done");
    endtask : t_fill_erase
    task t_disable;
        ctl(SEECE_CTL_DISABLE, 0, 16'h0);
        `CHK(wen, 1'b0)
        u_host.frame(SEECE_OP_ERASE, 6'h04, 0, 17'h0);
        `CHK(busy, 1'b0)
        rd(4'h4, 16'ha5a5);
        $display("test disable done");
    endtask : t_disable
    task t_clear;
        ctl(SEECE_CTL_ENABLE, 0, 16'h0);
        ctl(SEECE_CTL_CLEAR, 0, 16'h0);
        `CHK(busy, 1'b1)
        wait_idle();
        rd(4'h9, SEECE_ERASED_WORD);
        $display("test clear done");
    endtask : t_clear
    // A second reset stands for a power cycle and must leave the device locked.
    task t_power;
        `CHK(wen, 1'b1)
        u_host.wt(2);
        reset_i = 1'b1;
        u_host.wt(4);
        reset_i = 1'b0;
        `CHK({wen, busy, oe}, 3'h0)
        $display("test power cycle done");
    endtask : t_power
    initial
    begin
        reset_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_locked();
        t_write();
        t_fill_erase();
        t_disable();
        t_clear();
        t_power();
        final_report();
    end
    // About 2800 cycles are expected; the limit of 20000 cycles allows about seven times that.
    initial
    begin
        #400000;
        n_fail++;
        final_report();
    end
endmodule : seece_engine_tb

// *** verif/seece_host.sv ***
// Serial link controller model that issues frames to the command engine.
`timescale 1ns/1ns
module seece_host (
    input wire logic mclk_i,
    input wire logic oe_i,
    input wire logic out_i,
    output logic select_o,
    output logic serial_clock_in_o,
    output logic serial_in_o
);
    logic [16:0] q;
    initial
    begin
        select_o = 1'b0;
        serial_clock_in_o = 1'b0;
        serial_in_o = 1'b0;
        q = 17'h0;
    end
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : wt
    // Sampled just before the next rise; an undriven line reads as unknown.
    task bit_(input logic b);
        serial_in_o = b;
        wt(4);
        q = {q[15:0], oe_i ? out_i : 1'bx};
        serial_clock_in_o = 1'b1;
        wt(4);
        serial_clock_in_o = 1'b0;
    endtask : bit_
    task sel(input logic v);
        wt(1);
        select_o = v;
        if (!v)
        begin
            serial_in_o = ~serial_in_o;
        end
    endtask : sel
    // The clock stands still between frames; select falls before any further rise.
    task frame(input logic [1:0] op, input logic [5:0] a, input int n, input logic [16:0] d);
        int i;
        sel(1'b1);
        bit_(1'b0);
        bit_(1'b1);
        for (i = 1; i >= 0; i--) bit_(op[i]);
        for (i = 5; i >= 0; i--) bit_(a[i]);
        for (i = n - 1; i >= 0; i--) bit_(d[i]);
        sel(1'b0);
        wt(8);
    endtask : frame
endmodule : seece_host
